// ===== acfh_dev_model.sv
// acfh_dev_model: behavioural cell engine parameter area, big-endian bytes
// assumes req is held until ack; lat adds wait cycles before each ack
`timescale 1ns/1ps
module acfh_dev_model #(
   parameter logic [15:0] VERSION = 16'h5A3C // arbitrary value
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // parameter port
   input wire acfh_pkg::acfh_dev_req_s dev_out,
   output logic dev_ack,
   output logic [31:0] dev_rdata,
   // pacing
   input wire logic [3:0] lat
);
   logic [7:0] mem [0:255];
   logic [3:0] wait_q;
   logic [7:0] a;
   assign a = dev_out.addr;

   function automatic logic [31:0] rd(input logic [7:0] ad, input logic [1:0] sz);
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < (1 << sz); i++)
         v = {v[23:0], mem[ad + i[7:0]]};
      return v;
   endfunction

   // device-side events: status bits, logged header, counters
   task automatic raise(input logic [15:0] st, input logic [15:0] nm, input logic [15:0] herr,
      input logic [31:0] hdr);
      mem[8'h4A] = mem[8'h4A] | st[15:8];
      mem[8'h4B] = st[7:0];
      {mem[8'h4C], mem[8'h4D], mem[8'h4E], mem[8'h4F]} = hdr;
      {mem[8'h50], mem[8'h51]} = {mem[8'h50], mem[8'h51]} + nm;
      {mem[8'h52], mem[8'h53]} = {mem[8'h52], mem[8'h53]} + herr;
   endtask

   // filled with a marker so untouched locations stand out
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'hEE;
      {mem[8'h2C], mem[8'h2D]} = VERSION;
   end

   always @(posedge mclk or negedge rstn)
      if (!rstn)
      begin
         dev_ack <= 1'b0;
         wait_q <= 4'h0;
         dev_rdata <= 32'h0;
      end
      else if (dev_out.req && !dev_ack && wait_q >= lat)
      begin
         dev_ack <= 1'b1;
         wait_q <= 4'h0;
         dev_rdata <= rd(a, dev_out.size);
         if (dev_out.we)
            for (int i = 0; i < (1 << dev_out.size); i++)
               mem[a + i[7:0]] <= dev_out.wdata[8 * ((1 << dev_out.size) - 1 - i) +: 8];
      end
      else
      begin
         dev_ack <= 1'b0;
         wait_q <= dev_out.req ? wait_q + 4'h1 : 4'h0;
         dev_rdata <= ~dev_rdata;
      end
endmodule // acfh_dev_model

// ===== acfh_host.sv
// acfh_host: host that programs and watches one cell engine channel
// assumes a device parameter port with req/ack handshake and an AHB-Lite master
// Notes on behaviour
// - buffer bases written with top two bits cleared
// - bases change only through init, queues drained
// - byte counter locations never written
// - delineation counters never written
// - empty header and payload stored little endian
// - status halfword cleared at init, upper byte only cleared on the clear command
// - nonmatch counter cleared on command
// - mask written with bit 31 zero
// - bit 31 set only on final table entry
// - scratch locations never written
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module acfh_host #(
   parameter int POLL_CYCLES = acfh_pkg::POLL_CYCLES_DEF
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // device parameter port
   output acfh_pkg::acfh_dev_req_s dev_out,
   input wire logic dev_ack,
   input wire logic [31:0] dev_rdata
);
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} acfh_state_e;

   acfh_state_e state_q;
   acfh_pkg::acfh_op_e op_q;
   logic [4:0] idx_q;
   logic [4:0] last_idx;
   acfh_pkg::acfh_dev_req_s step_d;
   logic [4:0] pend_q;
   logic [4:0] pend_set;
   logic [4:0] pend_clr;
   logic cfg_err_q;
   logic init_done_q;
   logic [31:0] tx_base_q;
   logic [31:0] rx_base_q;
   logic [15:0] cam_sel_q;
   logic [31:0] empty_cell_header_q;
   logic [31:0] epay_q;
   logic [31:0] mask_q;
   logic [31:0] cfg_q;
   logic [31:0] table_q [acfh_pkg::TABLE_MAX];
   logic [15:0] version_q;
   logic [15:0] dstat_q;
   logic [31:0] nm_head_q;
   logic [15:0] nm_cnt_q;
   logic [15:0] hec_cnt_q;
   logic [4:0] n_entries;
   logic [31:0] poll_cnt_q;
   logic poll_tick;
   logic ph_q;
   logic ph_write_q;
   logic [7:0] ph_addr_q;
   logic [31:0] rd_d;
   logic bus_wr;

   function automatic logic [31:0] swap32(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction

   // address phase capture, one wait state in the data phase
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ph_q <= 1'b0;
         ph_write_q <= 1'b0;
         ph_addr_q <= 8'h00;
         hreadyout <= 1'b1;
      end
      else if (ph_q)
      begin
         ph_q <= 1'b0;
         hreadyout <= 1'b1;
      end
      else if (hsel && htrans[1] && hready)
      begin
         ph_q <= 1'b1;
         ph_write_q <= hwrite;
         ph_addr_q <= {haddr[7:2], 2'b00};
         hreadyout <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         hresp <= 1'b0;
      else
         hresp <= 1'b0;
   end

   assign bus_wr = ph_q && ph_write_q;

   // read mux, unmapped below REG_TABLE reads as zero; from REG_TABLE up the table repeats
   always_comb
   begin
      rd_d = 32'h0000_0000;
      if (ph_addr_q >= acfh_pkg::REG_TABLE)
         rd_d = table_q[ph_addr_q[5:2]];
      else
         case (ph_addr_q)
            acfh_pkg::REG_CTRL: rd_d = {27'h0000000, pend_q};
            acfh_pkg::REG_STAT: rd_d = {dstat_q, 13'h0000, init_done_q, cfg_err_q,
               state_q != ST_IDLE || pend_q != 5'h00};
            acfh_pkg::REG_TX_BASE: rd_d = tx_base_q;
            acfh_pkg::REG_RX_BASE: rd_d = rx_base_q;
            acfh_pkg::REG_CAM_SEL: rd_d = {16'h0000, cam_sel_q};
            acfh_pkg::REG_EMPTY_CELL_HEADER: rd_d = empty_cell_header_q;
            acfh_pkg::REG_EPAY: rd_d = epay_q;
            acfh_pkg::REG_MASK: rd_d = mask_q;
            acfh_pkg::REG_CFG: rd_d = cfg_q;
            acfh_pkg::REG_VERSION: rd_d = {16'h0000, version_q};
            acfh_pkg::REG_NM_HEAD: rd_d = nm_head_q;
            acfh_pkg::REG_COUNTS: rd_d = {nm_cnt_q, hec_cnt_q};
            default: rd_d = 32'h0000_0000;
         endcase
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         hrdata <= 32'h0000_0000;
      else if (ph_q && !ph_write_q)
         hrdata <= rd_d;
   end

   // software configuration registers
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_base_q <= 32'h0000_0000;
         rx_base_q <= 32'h0000_0000;
         cam_sel_q <= 16'h0000;
         empty_cell_header_q <= 32'h0000_0000;
         epay_q <= 32'h0000_0000;
         mask_q <= 32'h0000_0000;
         cfg_q <= 32'h0000_0000;
         for (int i = 0; i < acfh_pkg::TABLE_MAX; i++)
            table_q[i] <= 32'h0000_0000;
      end
      else if (bus_wr)
      begin
         if (ph_addr_q >= acfh_pkg::REG_TABLE)
            table_q[ph_addr_q[5:2]] <= hwdata;
         else
            case (ph_addr_q)
               acfh_pkg::REG_TX_BASE: tx_base_q <= hwdata;
               acfh_pkg::REG_RX_BASE: rx_base_q <= hwdata;
               acfh_pkg::REG_CAM_SEL: cam_sel_q <= hwdata[15:0];
               acfh_pkg::REG_EMPTY_CELL_HEADER: empty_cell_header_q <= hwdata;
               acfh_pkg::REG_EPAY: epay_q <= hwdata;
               acfh_pkg::REG_MASK: mask_q <= hwdata;
               acfh_pkg::REG_CFG: cfg_q <= hwdata;
               default: ;
            endcase
      end
   end

   // auto poll divider
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         poll_cnt_q <= 32'h0000_0000;
      else if (!cfg_q[acfh_pkg::CFG_AUTO_POLL] || poll_tick)
         poll_cnt_q <= 32'h0000_0000;
      else
         poll_cnt_q <= poll_cnt_q + 32'h0000_0001;
   end

   assign poll_tick = cfg_q[acfh_pkg::CFG_AUTO_POLL] &&
      poll_cnt_q == 32'(POLL_CYCLES - 1);

   // pending commands, a new request wins over completion
   assign pend_set = (bus_wr && ph_addr_q == acfh_pkg::REG_CTRL ? hwdata[4:0] : 5'h00) |
      {poll_tick, 4'h0};

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         pend_q <= 5'h00;
      else
         pend_q <= (pend_q & ~pend_clr) | pend_set;
   end

   // table length clamped to 1..16
   assign n_entries = cfg_q[acfh_pkg::CFG_CNT_LSB +: 5] == 5'h00 ? 5'h01 :
      cfg_q[acfh_pkg::CFG_CNT_LSB +: 5] > 5'h10 ? 5'h10 : cfg_q[acfh_pkg::CFG_CNT_LSB +: 5];

   always_comb
   begin
      case (op_q)
         acfh_pkg::OP_INIT: last_idx = acfh_pkg::INIT_FIXED + n_entries - 5'h01;
         acfh_pkg::OP_POLL: last_idx = acfh_pkg::POLL_LAST;
         default: last_idx = 5'h00;
      endcase
   end

   // access for the current step; byte counters, delineation and scratch never addressed
   always_comb
   begin
      step_d = '{req: 1'b1, we: 1'b1, size: acfh_pkg::SZ_WORD, addr: 8'h00,
         wdata: 32'h0000_0000};
      case (op_q)
         acfh_pkg::OP_INIT:
            case (idx_q)
               5'h00: step_d.addr = acfh_pkg::DEV_RX_BASE;
               5'h01: step_d.addr = acfh_pkg::DEV_TX_BASE;
               5'h02: step_d.addr = acfh_pkg::DEV_CAM_SEL;
               5'h03: step_d.addr = acfh_pkg::DEV_EMPTY_CELL_HEADER;
               5'h04: step_d.addr = acfh_pkg::DEV_EPAY;
               5'h05: step_d.addr = acfh_pkg::DEV_STATUS;
               5'h06: step_d.addr = acfh_pkg::DEV_NM_CNT;
               5'h07: step_d.addr = acfh_pkg::DEV_HEC_CNT;
               5'h08: step_d.addr = acfh_pkg::DEV_MASK;
               default: step_d.addr = acfh_pkg::DEV_TABLE +
                  {idx_q[3:0] - 4'h9, 2'b00};
            endcase
         acfh_pkg::OP_CLR_STAT:
         begin
            step_d.size = acfh_pkg::SZ_BYTE;
            step_d.addr = acfh_pkg::DEV_STATUS;
         end
         acfh_pkg::OP_CLR_NM: step_d.addr = acfh_pkg::DEV_NM_CNT;
         acfh_pkg::OP_CLR_HEC: step_d.addr = acfh_pkg::DEV_HEC_CNT;
         acfh_pkg::OP_POLL:
         begin
            step_d.we = 1'b0;
            case (idx_q)
               5'h00: step_d.addr = acfh_pkg::DEV_VERSION;
               5'h01: step_d.addr = acfh_pkg::DEV_STATUS;
               5'h02: step_d.addr = acfh_pkg::DEV_NM_HEAD;
               5'h03: step_d.addr = acfh_pkg::DEV_NM_CNT;
               default: step_d.addr = acfh_pkg::DEV_HEC_CNT;
            endcase
         end
         default: step_d.req = 1'b0;
      endcase
      if (op_q == acfh_pkg::OP_INIT)
         case (idx_q)
            5'h00: step_d.wdata = rx_base_q & acfh_pkg::TOP2_CLR;
            5'h01: step_d.wdata = tx_base_q & acfh_pkg::TOP2_CLR;
            5'h02: step_d.wdata = {16'h0000, cam_sel_q};
            5'h03: step_d.wdata = swap32(empty_cell_header_q);
            5'h04: step_d.wdata = swap32(epay_q);
            5'h05, 5'h06, 5'h07: step_d.wdata = 32'h0000_0000;
            5'h08: step_d.wdata = mask_q & ~acfh_pkg::LAST_BIT;
            default: step_d.wdata = (table_q[4'(idx_q - 5'h09)] & ~acfh_pkg::LAST_BIT) |
               (idx_q == last_idx ? acfh_pkg::LAST_BIT : 32'h0000_0000);
         endcase
      if (op_q == acfh_pkg::OP_INIT && (idx_q == 5'h02 || (idx_q >= 5'h05 && idx_q <= 5'h07)))
         step_d.size = acfh_pkg::SZ_HALF;
      if (op_q == acfh_pkg::OP_CLR_NM || op_q == acfh_pkg::OP_CLR_HEC)
         step_d.size = acfh_pkg::SZ_HALF;
      if (op_q == acfh_pkg::OP_POLL && idx_q != 5'h02)
         step_d.size = acfh_pkg::SZ_HALF;
   end

   // sequencer: pick an order, walk its steps over the device port
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_IDLE;
         op_q <= acfh_pkg::OP_NONE;
         idx_q <= 5'h00;
         cfg_err_q <= 1'b0;
         init_done_q <= 1'b0;
         dev_out <= '0;
      end
      else
         case (state_q)
            ST_IDLE:
            begin
               idx_q <= 5'h00;
               if (pend_q[acfh_pkg::CTL_INIT])
               begin
                  if (cfg_q[acfh_pkg::CFG_CAM_EN] && cam_sel_q == 16'h0000)
                  begin
                     cfg_err_q <= 1'b1;
                     op_q <= acfh_pkg::OP_NONE;
                  end
                  else
                  begin
                     cfg_err_q <= 1'b0;
                     init_done_q <= 1'b0;
                     op_q <= acfh_pkg::OP_INIT;
                     state_q <= ST_ISSUE;
                  end
               end
               else if (pend_q[acfh_pkg::CTL_CLR_STAT])
               begin
                  op_q <= acfh_pkg::OP_CLR_STAT;
                  state_q <= ST_ISSUE;
               end
               else if (pend_q[acfh_pkg::CTL_CLR_NM])
               begin
                  op_q <= acfh_pkg::OP_CLR_NM;
                  state_q <= ST_ISSUE;
               end
               else if (pend_q[acfh_pkg::CTL_CLR_HEC])
               begin
                  op_q <= acfh_pkg::OP_CLR_HEC;
                  state_q <= ST_ISSUE;
               end
               else if (pend_q[acfh_pkg::CTL_POLL])
               begin
                  op_q <= acfh_pkg::OP_POLL;
                  state_q <= ST_ISSUE;
               end
               else
                  op_q <= acfh_pkg::OP_NONE;
            end
            ST_ISSUE:
            begin
               dev_out <= step_d;
               state_q <= ST_WAIT;
            end
            ST_WAIT:
               if (dev_ack)
               begin
                  dev_out.req <= 1'b0;
                  if (idx_q == last_idx)
                  begin
                     state_q <= ST_IDLE;
                     if (op_q == acfh_pkg::OP_INIT)
                        init_done_q <= 1'b1;
                  end
                  else
                  begin
                     idx_q <= idx_q + 5'h01;
                     state_q <= ST_ISSUE;
                  end
               end
            default: state_q <= ST_IDLE;
         endcase
   end

   // completion and refusal retire the pending bit
   always_comb
   begin
      pend_clr = 5'h00;
      if (state_q == ST_IDLE && pend_q[acfh_pkg::CTL_INIT] &&
         cfg_q[acfh_pkg::CFG_CAM_EN] && cam_sel_q == 16'h0000)
         pend_clr[acfh_pkg::CTL_INIT] = 1'b1;
      if (state_q == ST_WAIT && dev_ack && idx_q == last_idx)
         case (op_q)
            acfh_pkg::OP_INIT: pend_clr[acfh_pkg::CTL_INIT] = 1'b1;
            acfh_pkg::OP_CLR_STAT: pend_clr[acfh_pkg::CTL_CLR_STAT] = 1'b1;
            acfh_pkg::OP_CLR_NM: pend_clr[acfh_pkg::CTL_CLR_NM] = 1'b1;
            acfh_pkg::OP_CLR_HEC: pend_clr[acfh_pkg::CTL_CLR_HEC] = 1'b1;
            acfh_pkg::OP_POLL: pend_clr[acfh_pkg::CTL_POLL] = 1'b1;
            default: pend_clr = 5'h00;
         endcase
   end

   // poll results
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         version_q <= 16'h0000;
         dstat_q <= 16'h0000;
         nm_head_q <= 32'h0000_0000;
         nm_cnt_q <= 16'h0000;
         hec_cnt_q <= 16'h0000;
      end
      else if (state_q == ST_WAIT && dev_ack && op_q == acfh_pkg::OP_POLL)
         case (idx_q)
            5'h00: version_q <= dev_rdata[15:0];
            5'h01: dstat_q <= dev_rdata[15:0];
            5'h02: nm_head_q <= dev_rdata;
            5'h03: nm_cnt_q <= dev_rdata[15:0];
            default: hec_cnt_q <= dev_rdata[15:0];
         endcase
   end
endmodule // acfh_host

// ===== acfh_host_monitor.sv
// acfh_host_monitor: bus and device port checks for the cell engine host
// assumes it is bound into acfh_host and sees only that module's ports
`timescale 1ns/1ps
module acfh_host_monitor (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // ahb-lite
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // device port
   input wire acfh_pkg::acfh_dev_req_s dev_out,
   input wire logic dev_ack
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   logic wr;
   assign wr = dev_out.req && dev_out.we;

   // one wait state, then ready again
   sequence s_wait_state;
      !hreadyout ##1 hreadyout;
   endsequence
   // request held with every field until acknowledged
   sequence s_held;
      dev_out.req && $stable(dev_out);
   endsequence

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   a_one_wait: assert property (hsel && htrans[1] && hready |=> s_wait_state)
      else $error("data phase not two cycles");
   a_req_holds: assert property (dev_out.req && !dev_ack |=> s_held)
      else $error("device request changed before ack");
   a_req_release: assert property (dev_out.req && dev_ack |=> !dev_out.req)
      else $error("device request not released after ack");
   a_base_clear: assert property (
      wr && dev_out.addr inside {8'h30, 8'h34} |-> dev_out.wdata[31:30] == 2'h0)
      else $error("buffer base written with top bits set");
   a_mask_clear: assert property (wr && dev_out.addr == 8'h64 |-> !dev_out.wdata[31])
      else $error("mask written with bit 31 set");
   a_counter_untouched: assert property (wr |-> !(dev_out.addr inside {8'h12, 8'h22}))
      else $error("byte counter written");
   a_delin_untouched: assert property (wr |-> !(dev_out.addr inside {8'h28, 8'h2A}))
      else $error("delineation counter written");
   a_scratch_untouched: assert property (
      wr |-> !(dev_out.addr inside {8'h14, 8'h24, 8'h40, 8'h46, 8'h48, [8'h54:8'h63]}))
      else $error("scratch location written");
   a_status_zero: assert property (wr && dev_out.addr == 8'h4A |-> dev_out.wdata == 32'h0)
      else $error("status written with nonzero value");
   a_version_kept: assert property (wr |-> dev_out.addr != 8'h2C)
      else $error("version location written");
endmodule // acfh_host_monitor

bind acfh_host acfh_host_monitor u_mon (.mclk(mclk), .rstn(rstn), .hsel(hsel), .htrans(htrans),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .dev_out(dev_out), .dev_ack(dev_ack));

// ===== acfh_host_test.sv
// acfh_host_test: self-checking bench for the cell engine host
// assumes acfh_dev_model on the device port and one ahb-lite slave
`timescale 1ns/1ps
module acfh_host_test;
   logic mclk;
   logic rstn;
   logic hsel;
   logic hwrite;
   logic hreadyout;
   logic hresp;
   logic [1:0] htrans;
   logic [7:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rv;
   logic [3:0] lat;
   logic dev_ack;
   logic [31:0] dev_rdata;
   acfh_pkg::acfh_dev_req_s dev_out;
   int errors;
   int total_checks;

   acfh_host #(.POLL_CYCLES(16)) u_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_out(dev_out),
      .dev_ack(dev_ack), .dev_rdata(dev_rdata));
   acfh_dev_model u_dev (.mclk(mclk), .rstn(rstn), .dev_out(dev_out), .dev_ack(dev_ack),
      .dev_rdata(dev_rdata), .lat(lat));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one single-word transfer; read data lands in rv
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask

   task automatic cmd(input logic [31:0] bits);
      logic [31:0] pend;
      int n;
      xfer(acfh_pkg::REG_CTRL, 1'b1, bits);
      n = 0;
      do
      begin
         xfer(acfh_pkg::REG_CTRL, 1'b0, 32'h0);
         pend = rv;
         xfer(acfh_pkg::REG_STAT, 1'b0, 32'h0);
         n++;
      end while ((pend[4:0] !== 5'h0 || rv[0] !== 1'b0) && n < 300);
      chk("command busy", 32'h0, {27'h0, pend[4:0] | {4'h0, rv[0]}});
   endtask

   task automatic t_reset();
      xfer(acfh_pkg::REG_STAT, 1'b0, 32'h0);
      chk("status after reset", 32'h0, rv);
      xfer(8'h30, 1'b1, 32'hFFFF_FFFF);
      xfer(8'h30, 1'b0, 32'h0);
      chk("unmapped read", 32'h0, rv);
   endtask

   task automatic t_refuse();
      xfer(acfh_pkg::REG_CAM_SEL, 1'b1, 32'h0);
      xfer(acfh_pkg::REG_CFG, 1'b1, 32'h0000_0001);
      cmd(32'h1);
      xfer(acfh_pkg::REG_STAT, 1'b0, 32'h0);
      chk("refused init flags", 32'h2, {29'h0, rv[2:0]});
      chk("rx base untouched", 32'hEEEE_EEEE, u_dev.rd(8'h30, 2'h2));
   endtask

   task automatic t_init();
      logic [31:0] tbl [3];
      tbl = '{32'h8000_0011, 32'h8000_0022, 32'h0000_0033};
      lat <= 4'h3;
      u_dev.raise(16'hC0FF, 16'h9, 16'h9, 32'h0);
      xfer(acfh_pkg::REG_TX_BASE, 1'b1, 32'hC000_1234);
      xfer(acfh_pkg::REG_RX_BASE, 1'b1, 32'h4000_5678);
      xfer(acfh_pkg::REG_CAM_SEL, 1'b1, 32'h0000_8001);
      xfer(acfh_pkg::REG_EMPTY_CELL_HEADER, 1'b1, 32'h0100_0000);
      xfer(acfh_pkg::REG_EPAY, 1'b1, 32'h6A6A_6A6A);
      xfer(acfh_pkg::REG_MASK, 1'b1, 32'h8FFF_FFF0);
      xfer(acfh_pkg::REG_CFG, 1'b1, 32'h0000_0301);
      for (int k = 0; k < 3; k++)
         xfer(acfh_pkg::REG_TABLE + 8'(4 * k), 1'b1, tbl[k]);
      cmd(32'h1);
      xfer(acfh_pkg::REG_STAT, 1'b0, 32'h0);
      chk("init done", 32'h1, {31'h0, rv[2]});
      chk("tx base", 32'h0000_1234, u_dev.rd(8'h34, 2'h2));
      chk("rx base", 32'h0000_5678, u_dev.rd(8'h30, 2'h2));
      chk("port select", 32'h8001, u_dev.rd(8'h2E, 2'h1));
      chk("empty header", 32'h0000_0001, u_dev.rd(8'h38, 2'h2));
      chk("empty payload", 32'h6A6A_6A6A, u_dev.rd(8'h3C, 2'h2));
      chk("status cleared", 32'h0, u_dev.rd(8'h4A, 2'h1));
      chk("nonmatch cleared", 32'h0, u_dev.rd(8'h50, 2'h1));
      chk("error count cleared", 32'h0, u_dev.rd(8'h52, 2'h1));
      chk("mask", 32'h0FFF_FFF0, u_dev.rd(8'h64, 2'h2));
      chk("entry 1", 32'h0000_0011, u_dev.rd(8'h68, 2'h2));
      chk("entry 2", 32'h0000_0022, u_dev.rd(8'h6C, 2'h2));
      chk("entry 3", 32'h8000_0033, u_dev.rd(8'h70, 2'h2));
      chk("entry 4", 32'hEEEE_EEEE, u_dev.rd(8'h74, 2'h2));
   endtask

   task automatic t_poll();
      lat <= 4'h0;
      u_dev.raise(16'h0301, 16'h5, 16'h7, 32'h1234_5670);
      cmd(32'h10);
      xfer(acfh_pkg::REG_STAT, 1'b0, 32'h0);
      chk("status lock and fifo", 32'h0301, {16'h0, rv[31:16]});
      xfer(acfh_pkg::REG_VERSION, 1'b0, 32'h0);
      chk("version", 32'h5A3C, rv);
      xfer(acfh_pkg::REG_NM_HEAD, 1'b0, 32'h0);
      chk("nonmatch header", 32'h1234_5670, rv);
      xfer(acfh_pkg::REG_COUNTS, 1'b0, 32'h0);
      chk("counts", 32'h0005_0007, rv);
   endtask

   task automatic t_clear();
      cmd(32'hE);
      chk("status upper cleared", 32'h0001, u_dev.rd(8'h4A, 2'h1));
      chk("nonmatch count", 32'h0, u_dev.rd(8'h50, 2'h1));
      chk("error count", 32'h0, u_dev.rd(8'h52, 2'h1));
      cmd(32'h10);
      xfer(acfh_pkg::REG_STAT, 1'b0, 32'h0);
      chk("status after clear", 32'h0001, {16'h0, rv[31:16]});
      xfer(acfh_pkg::REG_COUNTS, 1'b0, 32'h0);
      chk("counts after clear", 32'h0, rv);
   endtask

   // divider-driven polling picks up overrun and lost lock
   task automatic t_auto();
      u_dev.raise(16'h0200, 16'h2, 16'h0, 32'h0ABC_DEF0);
      xfer(acfh_pkg::REG_CFG, 1'b1, 32'h0000_0302);
      repeat (80) @(posedge mclk);
      xfer(acfh_pkg::REG_CFG, 1'b1, 32'h0000_0301);
      cmd(32'h0);
      xfer(acfh_pkg::REG_STAT, 1'b0, 32'h0);
      chk("auto poll status", 32'h0200, {16'h0, rv[31:16]});
      xfer(acfh_pkg::REG_NM_HEAD, 1'b0, 32'h0);
      chk("auto poll header", 32'h0ABC_DEF0, rv);
      xfer(acfh_pkg::REG_COUNTS, 1'b0, 32'h0);
      chk("auto poll counts", 32'h0002_0000, rv);
   endtask

   initial
   begin
      #200000;
      errors++;
      print_verdict();
   end

   initial
   begin
      errors = 0;
      total_checks = 0;
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      lat = 4'h0;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_refuse();
      t_init();
      t_poll();
      t_clear();
      t_auto();
      print_verdict();
   end
endmodule // acfh_host_test

// ===== acfh_pkg.sv
// acfh_pkg: shared constants and types for the cell engine host controller
// assumes the device parameter area is byte addressed with big-endian halfwords
package acfh_pkg;
   // device parameter offsets
   localparam logic [7:0] DEV_VERSION = 8'h2C;
   localparam logic [7:0] DEV_CAM_SEL = 8'h2E;
   localparam logic [7:0] DEV_RX_BASE = 8'h30;
   localparam logic [7:0] DEV_TX_BASE = 8'h34;
   localparam logic [7:0] DEV_EMPTY_CELL_HEADER = 8'h38;
   localparam logic [7:0] DEV_EPAY = 8'h3C;
   localparam logic [7:0] DEV_STATUS = 8'h4A;
   localparam logic [7:0] DEV_NM_HEAD = 8'h4C;
   localparam logic [7:0] DEV_NM_CNT = 8'h50;
   localparam logic [7:0] DEV_HEC_CNT = 8'h52;
   localparam logic [7:0] DEV_MASK = 8'h64;
   localparam logic [7:0] DEV_TABLE = 8'h68;
   localparam int TABLE_MAX = 16;
   // status halfword fields, lsb numbering
   localparam int STAT_RX_OVERFLOW_FLAG = 9;
   localparam int STAT_TX_STARVE_FLAG = 8;
   localparam int STAT_LOCK = 0;
   localparam logic [31:0] TOP2_CLR = 32'h3FFF_FFFF;
   localparam logic [31:0] LAST_BIT = 32'h8000_0000;
   // access sizes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   // own register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_TX_BASE = 8'h08;
   localparam logic [7:0] REG_RX_BASE = 8'h0C;
   localparam logic [7:0] REG_CAM_SEL = 8'h10;
   localparam logic [7:0] REG_EMPTY_CELL_HEADER = 8'h14;
   localparam logic [7:0] REG_EPAY = 8'h18;
   localparam logic [7:0] REG_MASK = 8'h1C;
   localparam logic [7:0] REG_CFG = 8'h20;
   localparam logic [7:0] REG_VERSION = 8'h24;
   localparam logic [7:0] REG_NM_HEAD = 8'h28;
   localparam logic [7:0] REG_COUNTS = 8'h2C;
   localparam logic [7:0] REG_TABLE = 8'h40;
   // control and config bits
   localparam int CTL_INIT = 0;
   localparam int CTL_CLR_STAT = 1;
   localparam int CTL_CLR_NM = 2;
   localparam int CTL_CLR_HEC = 3;
   localparam int CTL_POLL = 4;
   localparam int CFG_CAM_EN = 0;
   localparam int CFG_AUTO_POLL = 1;
   localparam int CFG_CNT_LSB = 8;
   localparam int POLL_CYCLES_DEF = 1024;
   localparam logic [4:0] POLL_LAST = 5'h04;
   localparam logic [4:0] INIT_FIXED = 5'h09;

   typedef enum logic [2:0] {OP_NONE, OP_INIT, OP_CLR_STAT, OP_CLR_NM, OP_CLR_HEC,
      OP_POLL} acfh_op_e;

   typedef struct packed {
      logic req;
      logic we;
      logic [1:0] size;
      logic [7:0] addr;
      logic [31:0] wdata;
   } acfh_dev_req_s;
endpackage
